// ==== hw/irs_dev.sv ====
// Slave end: register file reached over the two-wire link.
// Assumes the link clock comes from the master and stands still between
// frames; the register side runs on clk_i, takes link events by toggle and hands back a held read byte.
`timescale 1ns/1ps
// Behaviour
// - Bytes are eight bits, MSB first
// - Receiver acknowledges in the ninth clock
// - Start: data falls, stop: data rises, clock high
// - Data changes only while clock is low
// - Answer only address 5A hex
// - Acknowledge holds data low whole period
// - Master sends next byte after acknowledge
// - Slave only pulls lines low
// - No limit on bytes per frame
// - Master ends transfer with a stop
// - Single and burst access to every register
// - Write direction bit is zero
// - Acknowledge address, then index byte
// - Acknowledge every written data byte
// - Burst writes land at index onward
// - Burst reads continue while master acknowledges
// - Read: index write, repeated start, read
// - Enable low: acknowledge but no access
module irs_dev (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       enable_i,
  irs_link_if.slave                       link,
  input  wire logic [irs_pkg::IDX_W-1:0]  peek_idx_i,
  output logic [irs_pkg::BYTE_W-1:0]      peek_data_o,
  output logic                            wr_stb_o,
  output logic [irs_pkg::IDX_W-1:0]       wr_idx_o,
  output logic [irs_pkg::BYTE_W-1:0]      wr_data_o
);
  import irs_pkg::*;

  typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_INDEX = 3'b011,
                            ST_WDATA = 3'b010, ST_RDATA = 3'b110} irs_st_e;

  // Link side, clocked by edges of the bus clock and data lines
  logic             start_tgl, next_start_tgl;   // Flips on every start
  logic             stop_tgl, next_stop_tgl;     // Flips on every stop
  irs_st_e          st, next_st;                 // Byte role
  logic [3:0]       bitc, next_bitc;             // Bit slot 0..8
  logic [7:0]       shreg, next_shreg;           // Receive shifter
  logic [7:0]       tx, next_tx;                 // Byte being sent
  logic             ack, next_ack;               // Acknowledge owed
  logic             rw, next_rw;                 // Direction of the frame
  logic [IDX_W-1:0] ptr, next_ptr;               // Register pointer
  logic             start_seen, next_start_seen; // Last start handled
  logic             stop_seen, next_stop_seen;   // Last stop handled
  logic             xfer_tgl, next_xfer_tgl;     // Event to register side
  logic [IDX_W-1:0] xfer_idx, next_xfer_idx;     // Event index
  logic [7:0]       xfer_data, next_xfer_data;   // Event write data
  logic             xfer_wr, next_xfer_wr;       // Event is a write
  logic             sda_oe, next_sda_oe;         // Data pulled low
  logic [7:0]       byte_now;                    // Byte ending at this edge

  // Register side, clocked by clk_i
  logic [7:0]       regs [REG_DEPTH];            // Register storage
  logic             x_s1, x_s2, x_s3;            // Event toggle sync and edge
  logic             en_s1, en_s2;                // Enable pin sync
  logic [IDX_W-1:0] rd_ptr, next_rd_ptr;         // Prefetch pointer
  logic [7:0]       rd_data, next_rd_data;       // Prefetched byte
  logic             x_evt;                       // New event arrived
  logic             next_wr_stb;
  logic [IDX_W-1:0] next_wr_idx;
  logic [7:0]       next_wr_data;

  assign byte_now     = {shreg[6:0], link.sda};
  assign link.sda_s_o = 1'b0;                    // Never drives high
  assign link.sda_s_oe = sda_oe;

  // Bit of the outgoing byte for a slot, MSB first
  function automatic logic tx_bit(input logic [7:0] b, input logic [3:0] slot);
    tx_bit = b[3'(LAST_BIT - slot)];
  endfunction

  // Start detector: data falling while clock high
  always_comb begin
    next_start_tgl = link.scl ? ~start_tgl : start_tgl;
  end

  // The line is a clock here, so reset is asynchronous to it
  always_ff @(negedge link.sda or posedge rst_i) begin
    if (rst_i) start_tgl <= 1'b0;
    else start_tgl <= next_start_tgl;
  end

  // Stop detector: data rising while clock high
  always_comb begin
    next_stop_tgl = link.scl ? ~stop_tgl : stop_tgl;
  end

  always_ff @(posedge link.sda or posedge rst_i) begin
    if (rst_i) stop_tgl <= 1'b0;
    else stop_tgl <= next_stop_tgl;
  end

  // Receive and protocol state, sampled on rising clock
  always_comb begin
    next_st = st;       next_bitc = bitc;   next_shreg = shreg; next_tx = tx;
    next_ack = ack;     next_rw = rw;       next_ptr = ptr;
    next_start_seen = start_seen;          next_stop_seen = stop_seen;
    next_xfer_tgl = xfer_tgl; next_xfer_idx = xfer_idx;
    next_xfer_data = xfer_data; next_xfer_wr = xfer_wr;
    if (start_tgl != start_seen) begin     // Fresh start: first address bit
      next_start_seen = start_tgl;
      next_stop_seen  = stop_tgl;
      next_st    = ST_ADDR;                  // Repeated start allowed
      next_shreg = byte_now;
      next_bitc  = 4'h1;
      next_ack   = 1'b0;
    end else if (stop_tgl != stop_seen) begin  // Stop ends the frame
      next_stop_seen = stop_tgl;
      next_st = ST_IDLE;
    end else begin
      case (st)
        ST_IDLE: next_st = ST_IDLE;          // Ignore until a start
        ST_RDATA: begin
          if (bitc == ACK_SLOT) begin
            next_bitc = 4'h0;
            if (!link.sda) next_tx = rd_data;  // Master wants more
            else next_st = ST_IDLE;          // Not acknowledged: done
          end else begin
            next_bitc = bitc + 4'h1;
            if (bitc == LAST_BIT) begin      // Prefetch the next register
              next_ptr = ptr + 1'b1;
              next_xfer_idx = ptr + 1'b1;
              next_xfer_wr = 1'b0;
              next_xfer_tgl = ~xfer_tgl;
            end
          end
        end
        default: begin                       // Bytes flowing in
          if (bitc == ACK_SLOT) begin
            next_bitc = 4'h0;
            next_ack = 1'b0;
            case (st)
              ST_ADDR: begin
                if (!ack) next_st = ST_IDLE;
                else if (rw == DIR_RD) begin
                  next_st = ST_RDATA;
                  next_tx = rd_data;
                end else next_st = ST_INDEX;
              end
              default: next_st = ST_WDATA;   // Any number of bytes
            endcase
          end else begin
            next_shreg = byte_now;           // MSB arrives first
            next_bitc = bitc + 4'h1;
            if (bitc == LAST_BIT) begin
              case (st)
                ST_ADDR: begin
                  next_ack = byte_now[7:1] == DEV_ADDR;
                  next_rw = byte_now[0];
                end
                ST_INDEX: begin
                  next_ack = 1'b1;
                  next_ptr = byte_now;
                  next_xfer_idx = byte_now;
                  next_xfer_wr = 1'b0;
                  next_xfer_tgl = ~xfer_tgl;
                end
                default: begin
                  next_ack = 1'b1;
                  next_ptr = ptr + 1'b1;
                  next_xfer_idx = ptr;
                  next_xfer_data = byte_now;
                  next_xfer_wr = 1'b1;
                  next_xfer_tgl = ~xfer_tgl;
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge link.scl or posedge rst_i) begin
    if (rst_i) begin
      st <= ST_IDLE; bitc <= 4'h0; shreg <= 8'h00; tx <= 8'h00; ack <= 1'b0;
      rw <= 1'b0; ptr <= '0; start_seen <= 1'b0; stop_seen <= 1'b0;
      xfer_tgl <= 1'b0; xfer_idx <= '0; xfer_data <= 8'h00; xfer_wr <= 1'b0;
    end else begin
      st <= next_st; bitc <= next_bitc; shreg <= next_shreg; tx <= next_tx;
      ack <= next_ack; rw <= next_rw; ptr <= next_ptr;
      start_seen <= next_start_seen; stop_seen <= next_stop_seen;
      xfer_tgl <= next_xfer_tgl; xfer_idx <= next_xfer_idx;
      xfer_data <= next_xfer_data; xfer_wr <= next_xfer_wr;
    end
  end

  // Data drive, updated on falling clock so it moves only while low
  always_comb begin
    if (st == ST_RDATA) next_sda_oe = (bitc != ACK_SLOT) && !tx_bit(tx, bitc);
    else next_sda_oe = (st != ST_IDLE) && (bitc == ACK_SLOT) && ack;
  end

  always_ff @(negedge link.scl or posedge rst_i) begin
    if (rst_i) sda_oe <= 1'b0;
    else sda_oe <= next_sda_oe;
  end

  // Register side: events arrive by toggle; fields hold still for a byte time
  assign x_evt = x_s2 ^ x_s3;

  always_comb begin
    next_rd_ptr  = rd_ptr;
    next_wr_stb  = 1'b0;
    next_wr_idx  = wr_idx_o;
    next_wr_data = wr_data_o;
    if (x_evt) begin
      next_rd_ptr = xfer_wr ? IDX_W'(xfer_idx + 1'b1) : xfer_idx;
      if (xfer_wr && en_s2) begin            // Writes need enable high
        next_wr_stb  = 1'b1;
        next_wr_idx  = xfer_idx;
        next_wr_data = xfer_data;
      end
    end
    next_rd_data = en_s2 ? regs[rd_ptr] : RD_OFF;  // No read while disabled
  end

  // Synchronisers and register storage
  always_ff @(posedge clk_i) begin
    x_s1  <= xfer_tgl;
    x_s2  <= x_s1;
    en_s1 <= enable_i;
    en_s2 <= en_s1;
    if (rst_i) begin
      x_s3 <= 1'b0; rd_ptr <= '0; rd_data <= REG_RST; wr_stb_o <= 1'b0;
      wr_idx_o <= '0; wr_data_o <= 8'h00; peek_data_o <= REG_RST;
      for (int i = 0; i < REG_DEPTH; i++) regs[i] <= REG_RST;
    end else begin
      x_s3 <= x_s2; rd_ptr <= next_rd_ptr; rd_data <= next_rd_data;
      wr_stb_o <= next_wr_stb; wr_idx_o <= next_wr_idx; wr_data_o <= next_wr_data;
      peek_data_o <= regs[peek_idx_i];
      if (next_wr_stb) regs[next_wr_idx] <= next_wr_data;
    end
  end
endmodule

// ==== inc/irs_pkg.sv ====
// Shared constants for the two-wire register slave port and its master.
// Assumes both ends compile against this package before any module.
package irs_pkg;
  // Link framing
  localparam int unsigned BYTE_W  = 8;           // Bits per byte on the wire
  localparam int unsigned ADDR_W  = 7;           // Slave address width
  localparam logic [6:0]  DEV_ADDR = 7'h5A;      // Address the slave answers
  localparam logic        DIR_WR  = 1'b0;        // Direction bit for writes
  localparam logic        DIR_RD  = 1'b1;        // Direction bit for reads
  localparam logic [3:0]  ACK_SLOT = 4'h8;       // Bit slot of the acknowledge
  localparam logic [3:0]  LAST_BIT = 4'h7;       // Last data bit slot
  // Register file
  localparam int unsigned IDX_W     = 8;         // Register index width
  localparam int unsigned REG_DEPTH = 256;       // Registers behind the port
  localparam logic [7:0]  REG_RST   = 8'h00;     // Register reset value
  localparam logic [7:0]  RD_OFF    = 8'hFF;     // Read value while disabled
  // Master command port
  localparam int unsigned MAX_BYTES = 4;         // Bytes per command, most
  localparam int unsigned LEN_W     = 2;         // Byte count minus one
  localparam int unsigned BUF_W     = MAX_BYTES * BYTE_W;
  // Timing: bus clock made by the master from clk_i
  localparam int unsigned CLK_KHZ   = 100000;    // clk_i rate, 100 MHz
  localparam int unsigned SCL_KHZ   = 400;       // Highest bus clock rate
  // Quarter bus period in clk_i cycles, rounded up so the rate never exceeds
  localparam int unsigned QUARTER_CYC = (CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
  localparam int unsigned QCNT_W      = 7;
endpackage

// ==== inc/irs_link_if.sv ====
// Two-wire link between the master end and the register slave end.
// Assumes external pull-ups: a line is high unless some end enables its driver.
`timescale 1ns/1ps
interface irs_link_if;
  logic scl_m_oe;   // Master pulls the clock low
  logic scl_m_o;    // Master clock drive level, always low
  logic sda_m_oe;   // Master pulls data low
  logic sda_m_o;    // Master data drive level, always low
  logic sda_s_oe;   // Slave pulls data low
  logic sda_s_o;    // Slave data drive level, always low
  logic scl;        // Resolved clock line
  logic sda;        // Resolved data line

  // Wired-AND with pull-up: any enabled driver wins with its low level
  assign scl = scl_m_oe ? scl_m_o : 1'b1;
  assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

  modport master (output scl_m_oe, output scl_m_o, output sda_m_oe, output sda_m_o,
                  input scl, input sda);
  modport slave (output sda_s_oe, output sda_s_o, input scl, input sda);
endinterface

// ==== hw/irs_host.sv ====
// Master end: runs transfers on the two-wire link for a simple command port.
// Assumes clk_i at 100 MHz; makes the bus clock by a divider, no stretching.
`timescale 1ns/1ps
module irs_host (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       cmd_valid_i,
  output logic                            cmd_ready_o,
  input  wire logic                       cmd_read_i,
  input  wire logic [irs_pkg::IDX_W-1:0]  cmd_idx_i,
  input  wire logic [irs_pkg::LEN_W-1:0]  cmd_len_i,
  input  wire logic [irs_pkg::BUF_W-1:0]  cmd_wdata_i,
  output logic                            rsp_valid_o,
  output logic                            rsp_nack_o,
  output logic [irs_pkg::BUF_W-1:0]       rsp_rdata_o,
  irs_link_if.master                      link
);
  import irs_pkg::*;

  typedef enum logic [1:0] {H_IDLE = 2'b00, H_START = 2'b01, H_BIT = 2'b11,
                            H_STOP = 2'b10} irs_hst_e;
  typedef enum logic [2:0] {SG_ADDRW = 3'b000, SG_IDX = 3'b001, SG_WR = 3'b011,
                            SG_ADDRR = 3'b010, SG_RD = 3'b110} irs_seg_e;

  irs_hst_e          hst, next_hst;           // Bus step in progress
  irs_seg_e          seg, next_seg;           // Byte role within the transfer
  logic [1:0]        q, next_q;               // Quarter of the current step
  logic [QCNT_W-1:0] qcnt, next_qcnt;         // Divider for quarters
  logic [3:0]        bitc, next_bitc;         // Bit slot 0..8
  logic [7:0]        sh, next_sh;             // Byte shifter
  logic [LEN_W-1:0]  cnt, next_cnt;           // Data byte position
  logic [LEN_W-1:0]  len, next_len;           // Data bytes minus one
  logic [IDX_W-1:0]  idx, next_idx;           // Register index
  logic              rd, next_rd;             // Read transfer
  logic [BUF_W-1:0]  wbuf, next_wbuf;         // Write data bytes
  logic [BUF_W-1:0]  rbuf, next_rbuf;         // Read data bytes
  logic              nack, next_nack;         // Slave refused a byte
  logic              ackv, next_ackv;         // Sampled acknowledge level
  logic              scl_oe, next_scl_oe;     // Clock pulled low
  logic              sda_oe, next_sda_oe;     // Data pulled low
  logic              rsp, next_rsp;           // Completion pulse
  logic              sda_s1, sda_s2;          // Data line synchroniser
  logic              tick;                    // End of a quarter
  logic              rx_seg;                  // Byte flows from the slave

  assign tick        = qcnt == QCNT_W'(QUARTER_CYC - 1);
  assign rx_seg      = seg == SG_RD;
  assign cmd_ready_o = hst == H_IDLE;
  assign rsp_valid_o = rsp;
  assign rsp_nack_o  = nack;
  assign rsp_rdata_o = rbuf;
  assign link.scl_m_o  = 1'b0;               // Open drain: only ever low
  assign link.sda_m_o  = 1'b0;
  assign link.scl_m_oe = scl_oe;
  assign link.sda_m_oe = sda_oe;

  // Picks one data byte from a buffer
  function automatic logic [7:0] pick(input logic [BUF_W-1:0] b, input logic [LEN_W-1:0] n);
    pick = b[n*BYTE_W +: BYTE_W];
  endfunction

  // Next-state logic for the whole transfer engine
  always_comb begin
    next_hst = hst;  next_seg = seg;   next_q = q;       next_bitc = bitc;
    next_sh = sh;    next_cnt = cnt;   next_len = len;   next_idx = idx;
    next_rd = rd;    next_wbuf = wbuf; next_rbuf = rbuf; next_nack = nack;
    next_ackv = ackv; next_scl_oe = scl_oe; next_sda_oe = sda_oe;
    next_rsp = 1'b0;
    next_qcnt = tick ? '0 : qcnt + 1'b1;
    case (hst)
      H_IDLE: begin
        next_qcnt = '0;
        if (cmd_valid_i) begin                // Accept and latch a command
          next_hst = H_START;  next_seg = SG_ADDRW; next_q = 2'd0;
          next_rd = cmd_read_i; next_idx = cmd_idx_i; next_len = cmd_len_i;
          next_wbuf = cmd_wdata_i; next_cnt = '0; next_nack = 1'b0;
        end
      end
      H_START: if (tick) begin               // Start or repeated start
        next_q = q + 2'd1;
        case (q)
          2'd0: begin next_sda_oe = 1'b0; next_scl_oe = 1'b1; end
          2'd1: next_scl_oe = 1'b0;
          2'd2: next_sda_oe = 1'b1;          // Data falls with clock high
          default: begin
            next_scl_oe = 1'b1;  next_hst = H_BIT; next_bitc = 4'h0;
            next_sh = {DEV_ADDR, (seg == SG_ADDRR) ? DIR_RD : DIR_WR};
          end
        endcase
      end
      H_BIT: if (tick) begin
        next_q = q + 2'd1;
        case (q)
          2'd0: begin                        // Clock is low here
            if (bitc != ACK_SLOT) next_sda_oe = rx_seg ? 1'b0 : ~sh[7];  // MSB first
            else next_sda_oe = rx_seg && (cnt != len);  // Ack all but last read
          end
          2'd1: next_scl_oe = 1'b0;
          2'd2: begin                        // Sample while clock is high
            if (bitc == ACK_SLOT) next_ackv = sda_s2;
            else next_sh = {sh[6:0], rx_seg ? sda_s2 : 1'b0};
          end
          default: begin
            next_scl_oe = 1'b1;
            if (bitc != ACK_SLOT) next_bitc = bitc + 4'h1;
            else begin
              next_bitc = 4'h0;
              if (!rx_seg && ackv) begin     // Refused: end with stop
                next_nack = 1'b1; next_hst = H_STOP;
              end else begin                 // Next byte only after ack
                case (seg)
                  SG_ADDRW: begin next_seg = SG_IDX; next_sh = idx; end
                  SG_IDX: begin
                    if (rd) begin next_seg = SG_ADDRR; next_hst = H_START; end
                    else begin next_seg = SG_WR; next_sh = pick(wbuf, cnt); end
                  end
                  SG_WR: begin
                    if (cnt == len) next_hst = H_STOP;
                    else begin
                      next_cnt = cnt + 1'b1;
                      next_sh = pick(wbuf, LEN_W'(cnt + 1'b1));
                    end
                  end
                  SG_ADDRR: next_seg = SG_RD;
                  default: begin
                    next_rbuf[cnt*BYTE_W +: BYTE_W] = sh;
                    if (cnt == len) next_hst = H_STOP;
                    else next_cnt = cnt + 1'b1;
                  end
                endcase
              end
            end
          end
        endcase
      end
      H_STOP: if (tick) begin                // Stop: data rises, clock high
        next_q = q + 2'd1;
        case (q)
          2'd0: next_sda_oe = 1'b1;
          2'd1: next_scl_oe = 1'b0;
          2'd2: next_sda_oe = 1'b0;
          default: begin next_hst = H_IDLE; next_rsp = 1'b1; end
        endcase
      end
      default: next_hst = H_IDLE;
    endcase
  end

  // State registers; synchroniser first stage feeds only the second
  always_ff @(posedge clk_i) begin
    sda_s1 <= link.sda;
    sda_s2 <= sda_s1;
    if (rst_i) begin
      hst <= H_IDLE; seg <= SG_ADDRW; q <= 2'd0; qcnt <= '0; bitc <= 4'h0;
      sh <= 8'h00; cnt <= '0; len <= '0; idx <= '0; rd <= 1'b0; wbuf <= '0;
      rbuf <= '0; nack <= 1'b0; ackv <= 1'b0; scl_oe <= 1'b0; sda_oe <= 1'b0;
      rsp <= 1'b0;
    end else begin
      hst <= next_hst; seg <= next_seg; q <= next_q; qcnt <= next_qcnt;
      bitc <= next_bitc; sh <= next_sh; cnt <= next_cnt; len <= next_len;
      idx <= next_idx; rd <= next_rd; wbuf <= next_wbuf; rbuf <= next_rbuf;
      nack <= next_nack; ackv <= next_ackv; scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe; rsp <= next_rsp;
    end
  end
endmodule

// ==== tb/irs_link_props.sv ====
// Checker for the two-wire link joining the master end and the slave end.
// Assumes clk_i samples the lines much faster than the bus clock runs.
`timescale 1ns/1ps
module irs_link_props (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic scl_m_oe,
  input  wire logic scl_m_o,
  input  wire logic sda_m_oe,
  input  wire logic sda_m_o,
  input  wire logic sda_s_oe,
  input  wire logic sda_s_o,
  input  wire logic scl,
  input  wire logic sda
);
  logic       scl_q, sda_q;  // Line levels one clk_i earlier
  logic       first, rd;     // Address byte pending, read frame
  logic [3:0] bit_n;         // Bit slot within the byte, 8 is the acknowledge
  wire start = scl && scl_q && sda_q && !sda;
  wire rise  = scl && !scl_q;
  // Slot tracking; a start always reopens the address byte
  always_ff @(posedge clk_i) begin
    scl_q <= rst_i | scl;
    sda_q <= rst_i | sda;
    if (rst_i || start) begin
      bit_n <= 4'h0;
      first <= 1'b1;
      rd    <= 1'b0;
    end else if (rise) begin
      bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
      if (bit_n == 4'h8) first <= 1'b0;
      if (first && bit_n == 4'h7) rd <= sda;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_slave_low_only: assert property (sda_s_oe |-> !sda_s_o)
    else $error("slave drives data high");
  a_master_low_only: assert property (!(scl_m_oe && scl_m_o) && !(sda_m_oe && sda_m_o))
    else $error("master drives a line high");
  a_slave_hold_high: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave data moved while clock high");
  a_stop_slave_quiet: assert property (scl && $past(scl) && $rose(sda) |=> !sda_s_oe [*8])
    else $error("slave drives after stop");
  a_addr_acked: assert property (rise && first && bit_n == 4'h8 |-> sda_s_oe && !sda)
    else $error("address not acknowledged");
  a_addr_listen: assert property (rise && first && bit_n != 4'h8 |-> !sda_s_oe)
    else $error("slave drives during address bits");
  a_write_acked: assert property (rise && !first && !rd && bit_n == 4'h8 |-> !sda)
    else $error("written byte not acknowledged");
  // Slot 0 is left out: the stop rise lands there with the master pulling data
  a_read_master_off: assert property (rise && !first && rd
    && bit_n != 4'h0 && bit_n != 4'h8 |-> !sda_m_oe)
    else $error("master drives data during read bits");
endmodule

// ==== tb/tb_top.sv ====
// Testbench joining both ends over one link, driving the master command port.
// Assumes the master makes the bus clock itself; no bench link clock needed.
`timescale 1ns/1ps
module tb_top;
  import irs_pkg::*;
  logic        clk_i, rst_i, cmd_valid_i, cmd_read_i, enable_i;
  logic        cmd_ready_o, rsp_valid_o, rsp_nack_o, wr_stb_o;
  logic [7:0]  cmd_idx_i, peek_idx_i, peek_data_o, wr_idx_o, wr_data_o;
  logic [1:0]  cmd_len_i;
  logic [31:0] cmd_wdata_i, rsp_rdata_o;
  int          fail_count, cmp_count, stb_n;  // Mismatches, compares, write strobes
  irs_link_if link ();
  irs_host i_irs_host (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_read_i(cmd_read_i), .cmd_idx_i(cmd_idx_i),
    .cmd_len_i(cmd_len_i), .cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_o),
    .rsp_nack_o(rsp_nack_o), .rsp_rdata_o(rsp_rdata_o), .link(link));
  irs_dev i_irs_dev (.clk_i(clk_i), .rst_i(rst_i), .enable_i(enable_i), .link(link),
    .peek_idx_i(peek_idx_i), .peek_data_o(peek_data_o), .wr_stb_o(wr_stb_o),
    .wr_idx_o(wr_idx_o), .wr_data_o(wr_data_o));
  irs_link_props i_irs_link_props (.clk_i(clk_i), .rst_i(rst_i), .scl_m_oe(link.scl_m_oe),
    .scl_m_o(link.scl_m_o), .sda_m_oe(link.sda_m_oe), .sda_m_o(link.sda_m_o),
    .sda_s_oe(link.sda_s_oe), .sda_s_o(link.sda_s_o), .scl(link.scl), .sda(link.sda));
  // Clock, 100 MHz
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Count write strobes mid-cycle, away from the launching edge
  always @(negedge clk_i) if (wr_stb_o === 1'b1) stb_n++;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One command: valid for one edge (idle port is ready), then wait for the pulse
  task automatic xfer(input logic rd, input logic [7:0] idx, input logic [1:0] len,
                      input logic [31:0] wd);
    int n = 0;
    chk("ready", 32'h1, {31'h0, cmd_ready_o});
    cmd_valid_i <= 1'b1;
    cmd_read_i  <= rd;
    cmd_idx_i   <= idx;
    cmd_len_i   <= len;
    cmd_wdata_i <= wd;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    @(negedge clk_i);
    chk("busy", 32'h0, {31'h0, cmd_ready_o});
    do @(negedge clk_i); while (rsp_valid_o !== 1'b1 && ++n < 30000);
    chk("response", 32'h1, {31'h0, rsp_valid_o});
    chk("nack", 32'h0, {31'h0, rsp_nack_o});
    @(posedge clk_i);
  endtask
  task automatic peek(input logic [7:0] idx, input logic [7:0] exp);
    peek_idx_i <= idx;
    repeat (3) @(posedge clk_i);
    chk("register", {24'h0, exp}, {24'h0, peek_data_o});
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    // Scheduled, so the link flops with edge-triggered reset see it rise
    rst_i <= 1'b1;
    cmd_valid_i = 1'b0;
    cmd_read_i = 1'b0;
    cmd_idx_i = 8'h00;
    cmd_len_i = 2'h0;
    cmd_wdata_i = 32'h0;
    enable_i = 1'b1;
    peek_idx_i = 8'h00;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    xfer(1'b0, 8'h05, 2'h0, 32'h0000003C);
    chk("strobes", 32'h1, stb_n);
    peek(8'h05, 8'h3C);
    // Burst across the top of the index range, wraps to 00
    xfer(1'b0, 8'hFE, 2'h3, 32'h44332211);
    chk("strobes", 32'h5, stb_n);
    chk("last write", 32'h0144, {16'h0, wr_idx_o, wr_data_o});
    xfer(1'b1, 8'hFE, 2'h3, 32'h0);
    chk("read burst", 32'h44332211, rsp_rdata_o);
    // Enable low: still acknowledged, but no access
    enable_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    xfer(1'b0, 8'h05, 2'h0, 32'h000000AA);
    peek(8'h05, 8'h3C);
    chk("strobes", 32'h5, stb_n);
    xfer(1'b1, 8'hFE, 2'h0, 32'h0);
    chk("read off", {24'h0, RD_OFF}, {24'h0, rsp_rdata_o[7:0]});
    end_of_test();
  end
  // Watchdog, well beyond the five commands
  initial begin
    repeat (70000) @(posedge clk_i);
    fail_count++;
    end_of_test();
  end
endmodule
